// >>> verilog/lcc_consts.svh
// Sizes, counts and control-signal indices of the logic cluster
`ifndef LCC_CONSTS_SVH
`define LCC_CONSTS_SVH

// ----------------------------------------------------------------
// Cluster structure
// ----------------------------------------------------------------
`define LCC_CELLS        10
`define LCC_REGS         20
`define LCC_ROW_CLKS     6
`define LCC_ROW_SEL_W    3
`define LCC_RC_LINES     16
`define LCC_LOCAL_LINES  76
`define LCC_SEL_W        7
`define LCC_CTL_SEL_BASE 6
`define LCC_NUM_CLKS     3
`define LCC_NUM_SRCS     2
`define LCC_CLK_SEL_W    2
`define LCC_CLK_NONE     2'h3
`define LCC_MAX_CTL      10
`define LCC_CNT_W        4

// ----------------------------------------------------------------
// Cluster-wide control signal indices
// ----------------------------------------------------------------
`define LCC_NUM_CTL      7
`define LCC_CTL_ENA0     0
`define LCC_CTL_ACLR0    3
`define LCC_CTL_SCLR     5
`define LCC_CTL_SLOAD    6

// ----------------------------------------------------------------
// Memory-cluster variant
// ----------------------------------------------------------------
`define LCC_MEM_BITS     640
`define LCC_MEM_DEPTH    64
`define LCC_MEM_AW       6
`define LCC_MEM_NAW      5
`define LCC_MEM_W        20
`define LCC_MEM_WR_CLK   0
`define LCC_MEM_RD_CLK   1

`endif

// >>> verilog/lcc_pkg.sv
// Types shared by the logic cluster design
package lcc_pkg;

  typedef logic [6:0] lcc_sel_t;

  typedef enum logic [1:0]
  {
    LCC_MEM_64X1 = 2'h1,
    LCC_MEM_32X2 = 2'h2
  } lcc_mem_shape_t;

endpackage : lcc_pkg

// >>> verilog/lcc_cluster.sv
// Logic cluster: control block, routing, cell registers, LUT memory
`timescale 1ns/10ps
`include "lcc_consts.svh"

module lcc_cluster
  import lcc_pkg::*;
(
  input  wire logic                                   core_clk_i,
  input  wire logic                                   reset_i,
  input  wire logic [`LCC_ROW_CLKS-1:0]               row_clk_i,
  input  wire logic [`LCC_RC_LINES-1:0]               row_col_i,
  input  wire logic [`LCC_REGS-1:0]                   left_cell_i,
  input  wire logic [`LCC_REGS-1:0]                   right_cell_i,
  input  wire logic [1:0]                             chain_in_i,
  input  wire logic [`LCC_NUM_SRCS*`LCC_ROW_SEL_W-1:0] clk_src_row_i,
  input  wire logic [`LCC_NUM_CLKS-1:0]               clk_src_map_i,
  input  wire logic [`LCC_NUM_CLKS-1:0]               clk_edge_fall_i,
  input  wire logic [`LCC_NUM_CTL*`LCC_SEL_W-1:0]     ctl_sel_i,
  input  wire logic [`LCC_REGS*`LCC_SEL_W-1:0]        reg_src_sel_i,
  input  wire logic [`LCC_REGS*`LCC_CLK_SEL_W-1:0]    reg_clk_sel_i,
  input  wire logic [`LCC_REGS-1:0]                   reg_aclr_sel_i,
  input  wire logic [`LCC_REGS-1:0]                   reg_chain_en_i,
  input  wire logic [`LCC_CELLS-1:0]                  mem_cell_en_i,
  input  wire lcc_mem_shape_t                         mem_shape_i,
  input  wire logic                                   mem_wr_en_i,
  input  wire logic [`LCC_MEM_AW-1:0]                 mem_wr_addr_i,
  input  wire logic [`LCC_MEM_W-1:0]                  mem_wr_data_i,
  input  wire logic [`LCC_MEM_AW-1:0]                 mem_rd_addr_i,
  output logic      [`LCC_REGS-1:0]                   cell_out_o,
  output logic      [1:0]                             chain_out_o,
  output logic      [`LCC_MEM_W-1:0]                  mem_rd_data_o,
  output logic      [`LCC_NUM_CLKS-1:0]               cluster_clk_tick_o,
  output logic      [`LCC_CNT_W-1:0]                  active_ctl_count_o
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [`LCC_ROW_CLKS-1:0]    row_prev;
  logic [`LCC_NUM_SRCS-1:0]    src_rise;
  logic [`LCC_NUM_SRCS-1:0]    src_fall;
  logic [`LCC_NUM_CLKS-1:0]    clk_tick;
  logic [`LCC_NUM_CTL-1:0]     ctl_val;
  logic [`LCC_LOCAL_LINES-1:0] local_lines;
  logic [`LCC_REGS-1:0]        reg_q;
  logic [`LCC_MEM_W-1:0]       rd_q;
  logic [`LCC_CNT_W-1:0]       next_ctl_count;
  logic                        wide;
  logic [`LCC_MEM_DEPTH-1:0]   mem [`LCC_CELLS];

  assign wide = (mem_shape_i == LCC_MEM_32X2);

  // ----------------------------------------------------------------
  // Local routing
  // ----------------------------------------------------------------
  // Row/column lines, own outputs, and both neighbours' direct links
  assign local_lines = {right_cell_i,
                        left_cell_i,
                        cell_out_o,
                        row_col_i};

  function automatic logic pick_local(
    input logic [`LCC_LOCAL_LINES-1:0] lines,
    input lcc_sel_t                    sel
  );
    logic res;
    res = 1'b0;
    if (sel < lcc_sel_t'(`LCC_LOCAL_LINES))
    begin
      res = lines[sel];
    end
    return res;
  endfunction : pick_local

  // Control source: row clock line, or a local routing line above it
  function automatic logic pick_ctl(
    input logic [`LCC_ROW_CLKS-1:0]    rows,
    input logic [`LCC_LOCAL_LINES-1:0] lines,
    input lcc_sel_t                    sel
  );
    logic res;
    res = 1'b0;
    if (sel < lcc_sel_t'(`LCC_CTL_SEL_BASE))
    begin
      res = rows[sel[2:0]];
    end
    else
    begin
      res = pick_local(lines, sel - lcc_sel_t'(`LCC_CTL_SEL_BASE));
    end
    return res;
  endfunction : pick_ctl

  // ----------------------------------------------------------------
  // Clock sources and edge events
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      row_prev <= '0;
    end
    else
    begin
      row_prev <= row_clk_i;
    end
  end

  // Edge events compare this core cycle's row level with the last one.
  // A row select of six or more leaves the source stuck low.
  genvar s;
  generate
    for (s = 0; s < `LCC_NUM_SRCS; s++)
    begin : g_src
      logic [`LCC_ROW_SEL_W-1:0] row_sel;
      assign row_sel = clk_src_row_i[s*`LCC_ROW_SEL_W +: `LCC_ROW_SEL_W];
      always_comb
      begin
        src_rise[s]  = 1'b0;
        src_fall[s]  = 1'b0;
        if (row_sel < `LCC_ROW_SEL_W'(`LCC_ROW_CLKS))
        begin
          src_rise[s]  = row_clk_i[row_sel] & ~row_prev[row_sel];
          src_fall[s]  = ~row_clk_i[row_sel] & row_prev[row_sel];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Cluster-wide control signals
  // ----------------------------------------------------------------
  genvar k;
  generate
    for (k = 0; k < `LCC_NUM_CTL; k++)
    begin : g_ctl
      assign ctl_val[k] = pick_ctl(row_clk_i, local_lines,
                          ctl_sel_i[k*`LCC_SEL_W +: `LCC_SEL_W]);
    end
  endgenerate

  // Each cluster clock: one source, one edge, gated by its own enable.
  // Both edges of one source need two cluster clocks mapped to it.
  generate
    for (k = 0; k < `LCC_NUM_CLKS; k++)
    begin : g_clk
      logic edge_ev;
      assign edge_ev = clk_edge_fall_i[k] ? src_fall[clk_src_map_i[k]]
                                          : src_rise[clk_src_map_i[k]];
      assign clk_tick[k] = edge_ev &
                           ctl_val[`LCC_CTL_ENA0 + k];
    end
  endgenerate

  assign cluster_clk_tick_o = clk_tick;

  // Ten control signals at most: three clocks plus seven others
  always_comb
  begin
    next_ctl_count = '0;
    for (int i = 0; i < `LCC_NUM_CLKS; i++)
    begin
      next_ctl_count = next_ctl_count + `LCC_CNT_W'(clk_tick[i]);
    end
    for (int i = 0; i < `LCC_NUM_CTL; i++)
    begin
      next_ctl_count = next_ctl_count + `LCC_CNT_W'(ctl_val[i]);
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      active_ctl_count_o <= '0;
    end
    else
    begin
      active_ctl_count_o <= next_ctl_count;
    end
  end

  // ----------------------------------------------------------------
  // Cell registers, two per cell
  // ----------------------------------------------------------------
  genvar r;
  generate
    for (r = 0; r < `LCC_REGS; r++)
    begin : g_reg
      logic [`LCC_CLK_SEL_W-1:0] csel;
      logic                      tick;
      logic                      aclr;
      logic                      d_local;
      logic                      d_chain;
      assign csel    = reg_clk_sel_i[r*`LCC_CLK_SEL_W +: `LCC_CLK_SEL_W];
      assign tick    = (csel != `LCC_CLK_NONE) && clk_tick[csel];
      assign aclr    = ctl_val[`LCC_CTL_ACLR0 + reg_aclr_sel_i[r]];
      assign d_local = pick_local(local_lines,
                       reg_src_sel_i[r*`LCC_SEL_W +: `LCC_SEL_W]);
      if (r < 2)
      begin : g_head
        assign d_chain = chain_in_i[r];
      end
      else
      begin : g_link
        assign d_chain = reg_q[r-2];
      end

      always_ff @(posedge core_clk_i)
      begin
        if (reset_i)
        begin
          reg_q[r] <= 1'b0;
        end
        else if (mem_cell_en_i[r/2])
        begin
          reg_q[r] <= reg_q[r];
        end
        else if (aclr)
        begin
          reg_q[r] <= 1'b0;
        end
        else if (tick)
        begin
          if (ctl_val[`LCC_CTL_SCLR])
          begin
            reg_q[r] <= 1'b0;
          end
          else if (ctl_val[`LCC_CTL_SLOAD] || !reg_chain_en_i[r])
          begin
            reg_q[r] <= d_local;
          end
          else
          begin
            reg_q[r] <= d_chain;
          end
        end
      end
    end
  endgenerate

  assign chain_out_o = reg_q[`LCC_REGS-1 -: 2];

  // ----------------------------------------------------------------
  // Memory slices, one per cell
  // ----------------------------------------------------------------
  genvar c;
  generate
    for (c = 0; c < `LCC_CELLS; c++)
    begin : g_mem
      logic [`LCC_MEM_AW-1:0] wa0;
      logic [`LCC_MEM_AW-1:0] wa1;
      logic [`LCC_MEM_AW-1:0] ra0;
      logic [`LCC_MEM_AW-1:0] ra1;
      // 32x2: bit b of the slice lives in half b of its 64 cells
      assign wa0 = wide ? {1'b0, mem_wr_addr_i[`LCC_MEM_NAW-1:0]}
                        : mem_wr_addr_i;
      assign wa1 = {1'b1, mem_wr_addr_i[`LCC_MEM_NAW-1:0]};
      assign ra0 = wide ? {1'b0, mem_rd_addr_i[`LCC_MEM_NAW-1:0]}
                        : mem_rd_addr_i;
      assign ra1 = {1'b1, mem_rd_addr_i[`LCC_MEM_NAW-1:0]};

      // Write port on the first gated cluster clock
      always_ff @(posedge core_clk_i)
      begin
        if (mem_cell_en_i[c] && mem_wr_en_i &&
            clk_tick[`LCC_MEM_WR_CLK])
        begin
          if (wide)
          begin
            mem[c][wa0] <= mem_wr_data_i[2*c];
            mem[c][wa1] <= mem_wr_data_i[2*c+1];
          end
          else
          begin
            mem[c][wa0] <= mem_wr_data_i[c];
          end
        end
      end

      // Read port on its own cluster clock; old data on collision
      always_ff @(posedge core_clk_i)
      begin
        if (reset_i)
        begin
          rd_q[2*c+1 -: 2] <= 2'h0;
        end
        else if (mem_cell_en_i[c] && clk_tick[`LCC_MEM_RD_CLK])
        begin
          rd_q[2*c]   <= mem[c][ra0];
          rd_q[2*c+1] <= wide ? mem[c][ra1] : 1'b0;
        end
      end

      // Memory cell drives read data, else its two registers
      assign cell_out_o[2*c+1 -: 2] = mem_cell_en_i[c] ? rd_q[2*c+1 -: 2]
                                      : reg_q[2*c+1 -: 2];
    end
  endgenerate

  // ----------------------------------------------------------------
  // Read port data, gathered into memory word order
  // ----------------------------------------------------------------
  always_comb
  begin
    mem_rd_data_o = '0;
    for (int i = 0; i < `LCC_CELLS; i++)
    begin
      if (wide)
      begin
        mem_rd_data_o[2*i]   = rd_q[2*i];
        mem_rd_data_o[2*i+1] = rd_q[2*i+1];
      end
      else
      begin
        mem_rd_data_o[i] = rd_q[2*i];
      end
    end
  end

endmodule : lcc_cluster

// >>> dv/lcc_cluster_sva.sv
// Port assertions for the logic cluster
`timescale 1ns/10ps

module lcc_cluster_sva
  import lcc_pkg::*;
(
  input wire logic           core_clk_i,
  input wire logic           reset_i,
  input wire logic [5:0]     row_clk_i,
  input wire logic [15:0]    row_col_i,
  input wire logic [5:0]     clk_src_row_i,
  input wire logic [2:0]     clk_src_map_i,
  input wire logic [2:0]     clk_edge_fall_i,
  input wire logic [48:0]    ctl_sel_i,
  input wire logic [9:0]     mem_cell_en_i,
  input wire lcc_mem_shape_t mem_shape_i,
  input wire logic [19:0]    cell_out_o,
  input wire logic [1:0]     chain_out_o,
  input wire logic [19:0]    mem_rd_data_o,
  input wire logic [2:0]     cluster_clk_tick_o,
  input wire logic [3:0]     active_ctl_count_o
);
  logic [5:0] prev_row;

  default clocking @(posedge core_clk_i); endclocking
  default disable iff (reset_i);

  always_ff @(posedge core_clk_i)
    prev_row <= reset_i ? 6'h00 : row_clk_i;

  for (genvar k = 0; k < 3; k++)
  begin : g_clk
    logic [2:0] line;
    logic [6:0] ena_sel;
    logic       ena_low;
    assign line = clk_src_row_i[clk_src_map_i[k]*3 +: 3];
    assign ena_sel = ctl_sel_i[k*7 +: 7];
    // Enable taken from a row line or a row/column routing line
    assign ena_low = ena_sel < 7'h06 ? !row_clk_i[ena_sel[2:0]] :
      ena_sel < 7'h16 ? !row_col_i[ena_sel - 7'h06] : 1'b0;
    chk_tick_edge:
      assert property (cluster_clk_tick_o[k] |-> line < 3'h6 &&
        row_clk_i[line] != clk_edge_fall_i[k] &&
        prev_row[line] == clk_edge_fall_i[k])
      else $error("cluster tick without its source edge");
    chk_ena_gates:
      assert property (ena_low |-> !cluster_clk_tick_o[k])
      else $error("cluster tick while its enable is low");
  end

  chk_ctl_max:
    assert property (active_ctl_count_o <= 4'ha)
    else $error("too many active control signals");
  chk_ctl_floor:
    assert property (!$past(reset_i) |->
      active_ctl_count_o >= $countones($past(cluster_clk_tick_o)))
    else $error("control count below tick count");
  chk_reset_clear:
    assert property ($past(reset_i) |-> cell_out_o == 20'h00000 &&
      mem_rd_data_o == 20'h00000 && active_ctl_count_o == 4'h0)
    else $error("outputs not cleared by reset");
  chk_rd_hold:
    assert property (!$past(reset_i) && !$past(cluster_clk_tick_o[1]) &&
      $stable(mem_shape_i) && $stable(mem_cell_en_i)
      |-> $stable(mem_rd_data_o))
    else $error("read data moved without a read tick");
  chk_upper_zero:
    assert property (mem_shape_i != LCC_MEM_32X2 && $stable(mem_shape_i)
      |-> mem_rd_data_o[19:10] == 10'h000)
    else $error("upper read bits set in narrow mode");
  chk_chain_tap:
    assert property (!mem_cell_en_i[9] |-> chain_out_o == cell_out_o[19:18])
    else $error("chain output differs from last cell");

  cover property (cluster_clk_tick_o[2]);
  cover property (cluster_clk_tick_o[0] && cluster_clk_tick_o[1]);
  cover property (mem_shape_i == LCC_MEM_32X2 && cluster_clk_tick_o[1]);
endmodule : lcc_cluster_sva

bind lcc_cluster lcc_cluster_sva chk_u (.core_clk_i(core_clk_i),
  .reset_i(reset_i), .row_clk_i(row_clk_i), .row_col_i(row_col_i),
  .clk_src_row_i(clk_src_row_i),
  .clk_src_map_i(clk_src_map_i), .clk_edge_fall_i(clk_edge_fall_i),
  .ctl_sel_i(ctl_sel_i), .mem_cell_en_i(mem_cell_en_i),
  .mem_shape_i(mem_shape_i), .cell_out_o(cell_out_o),
  .chain_out_o(chain_out_o), .mem_rd_data_o(mem_rd_data_o),
  .cluster_clk_tick_o(cluster_clk_tick_o),
  .active_ctl_count_o(active_ctl_count_o));

// >>> dv/lcc_fabric_model.sv
// Routing fabric and neighbour clusters around the logic cluster
`timescale 1ns/10ps

module lcc_fabric_model #(parameter int HIGH_CYC = 2)
(
  input  wire logic        core_clk_i,
  input  wire logic        reset_i,
  input  wire logic [5:0]  pulse_i,
  input  wire logic [19:0] data_i,
  output logic      [5:0]  row_clk_o,
  output logic      [19:0] left_o,
  output logic      [19:0] right_o
);
  logic [3:0] high_cnt [6];

  // Row lines stand low between requested clock pulses
  always_ff @(posedge core_clk_i)
    for (int i = 0; i < 6; i++)
      high_cnt[i] <= reset_i ? 4'h0 : pulse_i[i] ? 4'(HIGH_CYC) :
                     high_cnt[i] - 4'(high_cnt[i] != 4'h0);

  always_comb
    for (int i = 0; i < 6; i++)
      row_clk_o[i] = high_cnt[i] != 4'h0;

  assign left_o = data_i;
  assign right_o = ~data_i;
endmodule : lcc_fabric_model

// >>> dv/lcc_cluster_tb.sv
// Self-checking bench for the logic cluster
`timescale 1ns/10ps

module lcc_cluster_tb
  import lcc_pkg::*;
;
  logic           core_clk_i = 1'b0;
  logic           reset_i = 1'b1;
  logic [5:0]     pulse = 6'h00, row_clk;
  logic [15:0]    row_col = 16'h0000;
  logic [19:0]    nb_data = 20'h00000, wr_data = 20'h00000;
  logic [19:0]    aclr_sel = 20'h00000, chain_en = 20'h00000;
  logic [39:0]    clk_sel = {20{2'h2}};
  logic [1:0]     chain_in = 2'h0, chain_out;
  logic [9:0]     mem_en = 10'h000;
  lcc_mem_shape_t shape = LCC_MEM_64X1;
  logic           wr_en = 1'b0;
  logic [5:0]     wr_addr = 6'h00, rd_addr = 6'h00;
  logic [19:0]    left_w, right_w, cell_out, rd_data;
  logic [2:0]     tick;
  logic [3:0]     count;
  logic [48:0]    ctl_sel;
  logic [139:0]   src_sel;
  int             num_errors = 0, checks = 0, cycles = 0;

  initial forever #4 core_clk_i = ~core_clk_i;

  lcc_fabric_model fab_u (.core_clk_i(core_clk_i), .reset_i(reset_i),
    .pulse_i(pulse), .data_i(nb_data), .row_clk_o(row_clk),
    .left_o(left_w), .right_o(right_w));

  lcc_cluster dut_u (.core_clk_i(core_clk_i), .reset_i(reset_i),
    .row_clk_i(row_clk), .row_col_i(row_col), .left_cell_i(left_w),
    .right_cell_i(right_w), .chain_in_i(chain_in),
    .clk_src_row_i(6'h08), .clk_src_map_i(3'b010),
    .clk_edge_fall_i(3'b100), .ctl_sel_i(ctl_sel), .reg_src_sel_i(src_sel),
    .reg_clk_sel_i(clk_sel), .reg_aclr_sel_i(aclr_sel),
    .reg_chain_en_i(chain_en), .mem_cell_en_i(mem_en), .mem_shape_i(shape),
    .mem_wr_en_i(wr_en), .mem_wr_addr_i(wr_addr), .mem_wr_data_i(wr_data),
    .mem_rd_addr_i(rd_addr), .cell_out_o(cell_out), .chain_out_o(chain_out),
    .mem_rd_data_o(rd_data), .cluster_clk_tick_o(tick),
    .active_ctl_count_o(count));

  task automatic cmp(input logic [19:0] got, input logic [19:0] exp);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  task automatic end_of_test();
    $display("checks=%0d mismatches=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_of_test

  // Ask the fabric for one pulse on the given row lines
  task automatic pulse_rows(input logic [5:0] m);
    pulse <= m;
    @(posedge core_clk_i);
    pulse <= 6'h00;
    repeat (6) @(posedge core_clk_i);
  endtask : pulse_rows

  // Same pulse; ticks seen on the rising edge [2:0] and falling edge [5:3]
  task automatic pulse_ticks(input logic [5:0] m, output logic [5:0] seen);
    pulse <= m;
    @(posedge core_clk_i);
    pulse <= 6'h00;
    @(posedge core_clk_i);
    seen[2:0] = tick;
    repeat (2) @(posedge core_clk_i);
    seen[5:3] = tick;
    repeat (3) @(posedge core_clk_i);
  endtask : pulse_ticks

  task automatic t_logic();
    logic [5:0] seen;
    nb_data <= 20'h5a3c6;
    row_col <= 16'h0004;
    pulse_ticks(6'h01, seen);
    cmp({14'h0000, seen}, 20'h00020);
    cmp(cell_out, 20'h5a3c6);
    nb_data <= 20'h0ffff;
    row_col <= 16'h0003;
    pulse_ticks(6'h03, seen);
    cmp({14'h0000, seen}, 20'h00003);
    cmp(cell_out, 20'h5a3c6);
    row_col <= 16'h0004;
    clk_sel <= {20{2'h3}};
    pulse_rows(6'h01);
    cmp(cell_out, 20'h5a3c6);
    clk_sel <= {20{2'h2}};
    chain_en <= 20'hfffff;
    chain_in <= 2'h3;
    pulse_rows(6'h01);
    cmp(cell_out, {20'h5a3c6 << 2} | 20'h00003);
    cmp({18'h00000, chain_out}, 20'h00001);
    row_col <= 16'h0044;
    pulse_rows(6'h01);
    cmp(cell_out, 20'h0ffff);
    chain_en <= 20'h00000;
    row_col <= 16'h0024;
    pulse_rows(6'h01);
    cmp(cell_out, 20'h00000);
    row_col <= 16'h0004;
    pulse_rows(6'h01);
    aclr_sel <= 20'hffc00;
    row_col <= 16'h0010;
    repeat (2) @(posedge core_clk_i);
    cmp(cell_out, 20'h003ff);
    cmp({16'h0000, count}, 20'h00001);
    row_col <= 16'h0000;
    $display("logic cell test done");
  endtask : t_logic

  task automatic t_mem();
    mem_en <= 10'h3ff;
    wr_en <= 1'b1;
    wr_addr <= 6'h05;
    rd_addr <= 6'h05;
    wr_data <= 20'h002a5;
    row_col <= 16'h0003;
    pulse_rows(6'h01);
    wr_data <= 20'h00153;
    pulse_rows(6'h03);
    cmp(rd_data, 20'h002a5);
    pulse_rows(6'h02);
    cmp(rd_data, 20'h00153);
    shape <= LCC_MEM_32X2;
    wr_addr <= 6'h23;
    wr_data <= 20'hc3a5e;
    rd_addr <= 6'h03;
    pulse_rows(6'h01);
    pulse_rows(6'h02);
    cmp(rd_data, 20'hc3a5e);
    shape <= LCC_MEM_64X1;
    rd_addr <= 6'h23;
    pulse_rows(6'h02);
    cmp(rd_data, 20'h00273);
    $display("memory test done");
  endtask : t_mem

  always @(posedge core_clk_i)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      num_errors++;
      end_of_test();
    end
  end

  initial
  begin
    for (int k = 0; k < 7; k++)
      ctl_sel[k*7 +: 7] = 7'(6 + k);
    for (int r = 0; r < 20; r++)
      src_sel[r*7 +: 7] = 7'(36 + r);
    repeat (6) @(posedge core_clk_i);
    reset_i <= 1'b0;
    @(posedge core_clk_i);
    @(posedge core_clk_i);
    cmp(cell_out, 20'h00000);
    cmp({16'h0000, count}, 20'h00000);
    $display("reset test done");
    t_logic();
    t_mem();
    end_of_test();
  end
endmodule : lcc_cluster_tb
